/* File: rtl/cmst_top.sv */
// Purpose: command-mode entry and exit, pending settings, sleep and wake timing
// Assumes: received bytes and commands come from parser logic on clk_sys_i
// Notes: sleep_pin_i is an asynchronous pin and is synchronised here
`timescale 1ns/1ps
`default_nettype none

module cmst_top #(
    parameter int CYCLES_PER_MS = cmst_pkg::CYCLES_PER_MS
) (
    input wire logic clk_sys_i,                     // system clock, 25 MHz
    input wire logic rst_i,                         // synchronous reset, active high
    input wire logic rx_valid_i,                    // one byte received from the host
    input wire logic [7:0] rx_byte_i,               // received byte value
    input wire logic cmd_valid_i,                   // decoded command strobe
    input wire logic cmd_write_i,                   // 1 write, 0 read
    input wire cmst_pkg::cmst_sel_t cmd_sel_i,      // register index or execution code
    input wire cmst_pkg::cmst_word_t cmd_wdata_i,   // value to write
    output cmst_pkg::cmst_word_t cmd_rdata_o,       // read value, valid with cmd_ok_o
    output logic cmd_ok_o,                          // command accepted pulse
    output logic cmd_err_o,                         // command refused pulse
    output logic cmd_mode_o,                        // command mode active
    output logic applied_o,                         // pending settings applied pulse
    input wire logic sleep_pin_i,                   // sleep request pin, high asks sleep
    input wire logic associated_i,                  // radio link associated
    input wire logic tx_busy_i,                     // transmission pending
    input wire logic rx_busy_i,                     // reception pending
    output logic asleep_o,                          // module is sleeping
    output logic radio_off_o,                       // radio released during sleep
    output logic stay_assoc_o,                      // sleeping but kept associated
    output logic host_hold_o                        // hold off serial output to host
);
    import cmst_pkg::*;

    // ==========================================================
    // decoding helpers
    function automatic logic value_ok(input cmst_sel_t idx, input cmst_word_t val);
        logic ok;
        ok = (val >= REG_MIN[idx]) && (val <= REG_MAX[idx]);
        if (idx == IDX_SLEEP_MODE_SELECT) begin
            ok = (val[7:0] == SM_NONE) || (val[7:0] == SM_PIN) ||
                 (val[7:0] == SM_CYCLIC) || (val[7:0] == SM_CYCLIC_PIN);
        end
        if (idx == IDX_SLEEP_OPTIONS) begin
            ok = ok && val[SO_NO_RESTART_BIT];
        end
        return ok;
    endfunction

    function automatic logic is_cyclic(input logic [7:0] mode);
        return (mode == SM_CYCLIC) || (mode == SM_CYCLIC_PIN);
    endfunction

    // ==========================================================
    // time base
    cmst_tick_if tick_bus ();

    cmst_timebase #(
        .CYCLES_PER_MS(CYCLES_PER_MS)
    ) u_timebase (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .ticks(tick_bus.src)
    );

    wire tick_1ms = tick_bus.tick_1ms;
    wire tick_10ms = tick_bus.tick_10ms;
    wire tick_100ms = tick_bus.tick_100ms;

    // ==========================================================
    // pin synchroniser
    logic pin_meta;
    logic pin_sync;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
        end else begin
            pin_meta <= sleep_pin_i;
            pin_sync <= pin_meta;
        end
    end

    // ==========================================================
    // settings: pending copy written by commands, active copy used by logic
    cmst_word_t pend [NUM_REGS];
    cmst_word_t act [NUM_REGS];
    logic [NUM_REGS-1:0] wr_en;
    logic apply;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
            always_ff @(posedge clk_sys_i) begin
                if (rst_i) begin
                    pend[gi] <= REG_RESET[gi];
                end else if (wr_en[gi]) begin
                    pend[gi] <= cmd_wdata_i;
                end
            end

            // active values only move on an apply, never on the write itself
            always_ff @(posedge clk_sys_i) begin
                if (rst_i) begin
                    act[gi] <= REG_RESET[gi];
                end else if (apply) begin
                    act[gi] <= pend[gi];
                end
            end
        end
    endgenerate

    wire [15:0] cfg_timeout = act[IDX_COMMAND_TIMEOUT][15:0];
    wire [15:0] cfg_guard = act[IDX_GUARD_TIME][15:0];
    wire [7:0] cfg_escape = act[IDX_ESCAPE_CHARACTER][7:0];
    wire [7:0] cfg_mode = act[IDX_SLEEP_MODE_SELECT][7:0];
    wire [23:0] cfg_period = act[IDX_SLEEP_PERIOD];
    wire [15:0] cfg_options = act[IDX_SLEEP_OPTIONS][15:0];
    wire [15:0] cfg_host_delay = act[IDX_WAKE_HOST_DELAY][15:0];
    wire [23:0] cfg_wake = act[IDX_CYCLIC_WAKE_TIME];
    wire [23:0] cfg_assoc = act[IDX_ASSOCIATION_TIMEOUT];

    // ==========================================================
    // line silence, counted in whole milliseconds since the last byte
    logic [15:0] sil_ms;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            sil_ms <= 16'h0000;
        end else if (rx_valid_i) begin
            sil_ms <= 16'h0000;
        end else if (tick_1ms && (sil_ms != 16'hffff)) begin
            sil_ms <= sil_ms + 16'h0001;
        end
    end

    wire guard_met = (sil_ms >= cfg_guard);
    wire is_escape = rx_valid_i && (rx_byte_i == cfg_escape);

    // ==========================================================
    // command mode entry and exit
    cmst_cm_state_t cm_q;
    cmst_cm_state_t next_cm;
    logic [15:0] idle_cnt;

    wire in_cmd = (cm_q == CM_CMD);
    wire cmd_take = cmd_valid_i && in_cmd;
    wire sel_is_reg = (cmd_sel_i < 4'(NUM_REGS));
    wire cmd_timed_out = in_cmd && (idle_cnt >= cfg_timeout);
    wire exit_req = cmd_take && (cmd_sel_i == SEL_EXIT_COMMAND);
    wire cm_exit = in_cmd && (exit_req || cmd_timed_out);
    wire cmd_good = cmd_take && (cmd_sel_i == SEL_APPLY_ACTION || cmd_sel_i == SEL_EXIT_COMMAND ||
                                 (sel_is_reg && (!cmd_write_i || value_ok(cmd_sel_i, cmd_wdata_i))));

    assign apply = (cmd_take && (cmd_sel_i == SEL_APPLY_ACTION)) || cm_exit;

    always_comb begin
        next_cm = cm_q;
        case (cm_q)
            CM_SILENCE: begin
                // the first escape only counts after a full guard silence
                if (is_escape && guard_met) begin
                    next_cm = CM_ESC1;
                end
            end
            CM_ESC1: begin
                if (rx_valid_i) begin
                    next_cm = is_escape ? CM_ESC2 : CM_SILENCE;
                end
            end
            CM_ESC2: begin
                if (rx_valid_i) begin
                    next_cm = is_escape ? CM_POST : CM_SILENCE;
                end
            end
            CM_POST: begin
                if (rx_valid_i) begin
                    next_cm = CM_SILENCE;
                end else if (guard_met) begin
                    next_cm = CM_CMD;
                end
            end
            CM_CMD: begin
                if (cm_exit) begin
                    next_cm = CM_SILENCE;
                end
            end
            default: begin
                next_cm = CM_SILENCE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            cm_q <= CM_SILENCE;
        end else begin
            cm_q <= next_cm;
        end
    end

    // inactivity restarts on entry and on each accepted command
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            idle_cnt <= 16'h0000;
        end else if (!in_cmd || cmd_good) begin
            idle_cnt <= 16'h0000;
        end else if (tick_100ms && (idle_cnt != 16'hffff)) begin
            idle_cnt <= idle_cnt + 16'h0001;
        end
    end

    // ==========================================================
    // command port answers
    always_comb begin
        for (int i = 0; i < NUM_REGS; i++) begin
            wr_en[i] = cmd_good && cmd_write_i && (cmd_sel_i == 4'(i));
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            cmd_ok_o <= 1'b0;
            cmd_err_o <= 1'b0;
            cmd_rdata_o <= 24'h000000;
            applied_o <= 1'b0;
        end else begin
            cmd_ok_o <= cmd_good;
            // outside command mode every command is refused
            cmd_err_o <= cmd_valid_i && !cmd_good;
            if (cmd_good && !cmd_write_i && sel_is_reg) begin
                cmd_rdata_o <= pend[cmd_sel_i];
            end
            applied_o <= apply;
        end
    end

    assign cmd_mode_o = in_cmd;

    // ==========================================================
    // sleep sequencing
    cmst_sl_state_t sl_q;
    cmst_sl_state_t next_sl;
    logic [23:0] sl_tmr;
    logic [15:0] hd_cnt;

    wire mode_pin = (cfg_mode == SM_PIN);
    wire mode_cyc = is_cyclic(cfg_mode);
    wire pin_wake = (cfg_mode == SM_CYCLIC_PIN);
    wire xfer_busy = tx_busy_i || rx_busy_i;

    always_comb begin
        next_sl = sl_q;
        case (sl_q)
            SL_AWAKE: begin
                if (!in_cmd && mode_pin && pin_sync) begin
                    next_sl = SL_ASSOC;
                end else if (!in_cmd && mode_cyc) begin
                    next_sl = SL_WAKE;
                end
            end
            SL_ASSOC: begin
                if (!(mode_pin || mode_cyc) || (mode_pin && !pin_sync)) begin
                    next_sl = SL_AWAKE;
                end else if (associated_i || (sl_tmr >= cfg_assoc)) begin
                    next_sl = SL_SLEEP;
                end
            end
            SL_SLEEP: begin
                if (!(mode_pin || mode_cyc)) begin
                    next_sl = SL_AWAKE;
                end else if (mode_pin && !pin_sync) begin
                    next_sl = SL_AWAKE;
                end else if (mode_cyc && ((sl_tmr >= cfg_period) || (pin_wake && !pin_sync))) begin
                    next_sl = SL_WAKE;
                end
            end
            SL_WAKE: begin
                // the wake window is never refreshed by received data
                if (!mode_cyc) begin
                    next_sl = SL_AWAKE;
                end else if (sl_tmr >= cfg_wake) begin
                    next_sl = SL_DRAIN;
                end
            end
            SL_DRAIN: begin
                if (!mode_cyc) begin
                    next_sl = SL_AWAKE;
                end else if (!xfer_busy && !in_cmd) begin
                    next_sl = SL_ASSOC;
                end
            end
            default: begin
                next_sl = SL_AWAKE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            sl_q <= SL_AWAKE;
        end else begin
            sl_q <= next_sl;
        end
    end

    // one shared timer, cleared on each state change; sleep counts 10 ms, the others 1 ms
    wire sl_tick = (sl_q == SL_SLEEP) ? tick_10ms : tick_1ms;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            sl_tmr <= 24'h000000;
        end else if (next_sl != sl_q) begin
            sl_tmr <= 24'h000000;
        end else if (sl_tick && (sl_tmr != 24'hffffff)) begin
            sl_tmr <= sl_tmr + 24'h000001;
        end
    end

    // ==========================================================
    // wake-host delay
    wire wake_evt = (sl_q == SL_SLEEP) && (next_sl != SL_SLEEP);

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            hd_cnt <= 16'h0000;
        end else if (wake_evt) begin
            hd_cnt <= cfg_host_delay;
        end else if (rx_valid_i) begin
            hd_cnt <= 16'h0000;
        end else if (tick_1ms && (hd_cnt != 16'h0000)) begin
            hd_cnt <= hd_cnt - 16'h0001;
        end
    end

    // ==========================================================
    // outputs
    wire sleeping = (sl_q == SL_SLEEP);

    assign asleep_o = sleeping;
    assign stay_assoc_o = sleeping && cfg_options[SO_STAY_ASSOC_BIT];
    assign radio_off_o = sleeping && !cfg_options[SO_STAY_ASSOC_BIT];
    assign host_hold_o = sleeping || (hd_cnt != 16'h0000);
endmodule

`default_nettype wire

/* File: common/cmst_pkg.sv */
// Purpose: shared constants and types for the command-mode and sleep timing block
// Assumes: 25 MHz system clock, one clock domain
// Notes: register indices double as the selector codes of the command port
//
// Functional notes
// - leave command mode after command_timeout x100 ms with no valid command
// - apply all pending settings whenever command mode ends, by exit or timeout
// - entry needs guard_time x1 ms of line silence before and after escapes
// - enter command mode only on silence, three escape characters, silence
// - escape_character is a programmable 8-bit value, default 0x2b
// - sleep_mode_select: 0 none, 1 pin, 4 cyclic, 5 cyclic with pin wake
// - sleep_options bit 6 modifies sleep behaviour beside the mode
// - sleep for sleep_period in 10 ms units, default 0xc8
// - option 0x40 keeps the link associated while asleep
// - option 0x100 must stay set; receptions never restart the wake timer
// - wait wake_host_delay ms after waking before sending to the host
// - any received serial character stops the wake-host delay at once
// - cyclic wake lasts cyclic_wake_time ms and new data never refreshes it
// - after wake time expires, finish pending transfers before sleeping
// - wait up to association_timeout ms for association before deep sleep
// - written settings stay pending until an apply action occurs

package cmst_pkg;

    // ==========================================================
    // timing
    localparam int CLK_HZ = 25_000_000;
    localparam int TIME_BASE_US = 1000;
    localparam int CYCLES_PER_MS = CLK_HZ / 1_000_000 * TIME_BASE_US;
    localparam int MS_PER_10MS = 10;
    localparam int TENS_PER_100MS = 10;

    // ==========================================================
    // types
    typedef logic [3:0] cmst_sel_t;
    typedef logic [23:0] cmst_word_t;

    // ==========================================================
    // register indices and execution selectors
    localparam int NUM_REGS = 9;
    localparam cmst_sel_t IDX_COMMAND_TIMEOUT = 4'h0;
    localparam cmst_sel_t IDX_GUARD_TIME = 4'h1;
    localparam cmst_sel_t IDX_ESCAPE_CHARACTER = 4'h2;
    localparam cmst_sel_t IDX_SLEEP_MODE_SELECT = 4'h3;
    localparam cmst_sel_t IDX_SLEEP_PERIOD = 4'h4;
    localparam cmst_sel_t IDX_SLEEP_OPTIONS = 4'h5;
    localparam cmst_sel_t IDX_WAKE_HOST_DELAY = 4'h6;
    localparam cmst_sel_t IDX_CYCLIC_WAKE_TIME = 4'h7;
    localparam cmst_sel_t IDX_ASSOCIATION_TIMEOUT = 4'h8;
    localparam cmst_sel_t SEL_APPLY_ACTION = 4'h9;
    localparam cmst_sel_t SEL_EXIT_COMMAND = 4'ha;

    // reset, minimum and maximum values, by index
    localparam cmst_word_t REG_RESET [NUM_REGS] = '{
        24'h000064, 24'h0003e8, 24'h00002b, 24'h000000, 24'h0000c8,
        24'h000100, 24'h000000, 24'h0007d0, 24'h002710};
    localparam cmst_word_t REG_MIN [NUM_REGS] = '{
        24'h000002, 24'h000002, 24'h000000, 24'h000000, 24'h000001,
        24'h000100, 24'h000000, 24'h000001, 24'h000001};
    localparam cmst_word_t REG_MAX [NUM_REGS] = '{
        24'h001770, 24'h000ce4, 24'h0000ff, 24'h000005, 24'h83d600,
        24'h0001ff, 24'h00ffff, 24'h36ee80, 24'h36ee80};

    // ==========================================================
    // field values
    localparam logic [7:0] SM_NONE = 8'h00;
    localparam logic [7:0] SM_PIN = 8'h01;
    localparam logic [7:0] SM_CYCLIC = 8'h04;
    localparam logic [7:0] SM_CYCLIC_PIN = 8'h05;
    localparam int SO_STAY_ASSOC_BIT = 6;
    localparam int SO_NO_RESTART_BIT = 8;

    // ==========================================================
    // state encodings, gray between neighbours in the listed order
    typedef enum logic [2:0] {
        CM_SILENCE = 3'h0,
        CM_ESC1 = 3'h1,
        CM_ESC2 = 3'h3,
        CM_POST = 3'h2,
        CM_CMD = 3'h6
    } cmst_cm_state_t;

    typedef enum logic [2:0] {
        SL_AWAKE = 3'h0,
        SL_ASSOC = 3'h1,
        SL_SLEEP = 3'h3,
        SL_WAKE = 3'h2,
        SL_DRAIN = 3'h6
    } cmst_sl_state_t;

endpackage

/* File: common/cmst_tick_if.sv */
// Purpose: carries the shared millisecond time-base ticks
// Assumes: all ticks are one-cycle pulses on clk_sys_i
// Notes: tick_10ms and tick_100ms coincide with a tick_1ms
`timescale 1ns/1ps
`default_nettype none

interface cmst_tick_if;
    logic tick_1ms;
    logic tick_10ms;
    logic tick_100ms;

    modport src (output tick_1ms, output tick_10ms, output tick_100ms);
    modport dst (input tick_1ms, input tick_10ms, input tick_100ms);
endinterface

`default_nettype wire

/* File: rtl/cmst_timebase.sv */
// Purpose: free-running prescaler making 1, 10 and 100 ms ticks
// Assumes: CYCLES_PER_MS at least 2
// Notes: runs from reset and never stops, so every timeout shares one base
`timescale 1ns/1ps
`default_nettype none

module cmst_timebase #(
    parameter int CYCLES_PER_MS = cmst_pkg::CYCLES_PER_MS
) (
    input wire logic clk_sys_i,   // system clock
    input wire logic rst_i,       // synchronous reset, active high
    cmst_tick_if.src ticks        // tick outputs
);
    import cmst_pkg::*;

    localparam logic [23:0] CYC_LAST = 24'(CYCLES_PER_MS - 1);
    localparam logic [3:0] MS_LAST = 4'(MS_PER_10MS - 1);
    localparam logic [3:0] TEN_LAST = 4'(TENS_PER_100MS - 1);

    logic [23:0] cyc_cnt;
    logic [3:0] ms_cnt;
    logic [3:0] ten_cnt;
    logic tick_1ms_q;
    logic tick_10ms_q;
    logic tick_100ms_q;

    wire cyc_wrap = (cyc_cnt == CYC_LAST);
    wire ms_wrap = cyc_wrap && (ms_cnt == MS_LAST);
    wire ten_wrap = ms_wrap && (ten_cnt == TEN_LAST);

    // ==========================================================
    // cascade of counters
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            cyc_cnt <= 24'h000000;
            ms_cnt <= 4'h0;
            ten_cnt <= 4'h0;
        end else begin
            cyc_cnt <= cyc_wrap ? 24'h000000 : cyc_cnt + 24'h000001;
            if (cyc_wrap) begin
                ms_cnt <= (ms_cnt == MS_LAST) ? 4'h0 : ms_cnt + 4'h1;
            end
            if (ms_wrap) begin
                ten_cnt <= (ten_cnt == TEN_LAST) ? 4'h0 : ten_cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            tick_1ms_q <= 1'b0;
            tick_10ms_q <= 1'b0;
            tick_100ms_q <= 1'b0;
        end else begin
            tick_1ms_q <= cyc_wrap;
            tick_10ms_q <= ms_wrap;
            tick_100ms_q <= ten_wrap;
        end
    end

    assign ticks.tick_1ms = tick_1ms_q;
    assign ticks.tick_10ms = tick_10ms_q;
    assign ticks.tick_100ms = tick_100ms_q;
endmodule

`default_nettype wire

/* File: tb/cmst_checker.sv */
// Purpose: port assertions for cmst_top
// Assumes: one clock, synchronous reset
// Notes: bound to every cmst_top below
`timescale 1ns/1ps
`default_nettype none
module cmst_checker
    import cmst_pkg::*;
#(
    parameter int CYCLES_PER_MS = 4
) (
    input wire logic clk_sys_i, // clock
    input wire logic rst_i, // reset
    input wire logic rx_valid_i, // rx strobe
    input wire logic cmd_valid_i, // cmd strobe
    input wire logic cmd_write_i, // write flag
    input wire cmst_pkg::cmst_sel_t cmd_sel_i, // selector
    input wire cmst_pkg::cmst_word_t cmd_wdata_i, // write value
    input wire logic cmd_ok_o, // accepted
    input wire logic cmd_err_o, // refused
    input wire logic cmd_mode_o, // command mode
    input wire logic applied_o, // applied
    input wire logic asleep_o, // asleep
    input wire logic radio_off_o, // radio off
    input wire logic stay_assoc_o, // kept associated
    input wire logic host_hold_o // host hold
);
    // ==========================================================
    // properties
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    sequence s_exit_req;
        cmd_valid_i && cmd_mode_o && cmd_sel_i == SEL_EXIT_COMMAND;
    endsequence
    sequence s_exit_done;
        cmd_ok_o && applied_o && !cmd_mode_o;
    endsequence
    property p_exit;
        s_exit_req |=> s_exit_done;
    endproperty
    a_exit: assert property (p_exit) else $error("exit not done");
    property p_fall;
        $fell(cmd_mode_o) |-> applied_o;
    endproperty
    a_fall: assert property (p_fall) else $error("mode left unapplied");
    property p_answer;
        cmd_valid_i |=> cmd_ok_o != cmd_err_o;
    endproperty
    a_answer: assert property (p_answer) else $error("no single answer");
    property p_refuse;
        cmd_valid_i && !cmd_mode_o |=> cmd_err_o;
    endproperty
    a_refuse: assert property (p_refuse) else $error("command outside mode");
    property p_apply;
        cmd_valid_i && cmd_mode_o && cmd_sel_i == SEL_APPLY_ACTION |=> applied_o && cmd_ok_o;
    endproperty
    a_apply: assert property (p_apply) else $error("apply missing");
    property p_pending;
        cmd_valid_i && cmd_write_i && cmd_sel_i < SEL_APPLY_ACTION |=> !applied_o;
    endproperty
    a_pending: assert property (p_pending) else $error("write applied at once");
    property p_opt;
        cmd_valid_i && cmd_write_i && cmd_sel_i == IDX_SLEEP_OPTIONS && !cmd_wdata_i[SO_NO_RESTART_BIT] |=> cmd_err_o;
    endproperty
    a_opt: assert property (p_opt) else $error("option bit accepted");
    property p_radio;
        asleep_o == (radio_off_o | stay_assoc_o) && !(radio_off_o & stay_assoc_o);
    endproperty
    a_radio: assert property (p_radio) else $error("radio state wrong");
    property p_hold;
        asleep_o |-> host_hold_o;
    endproperty
    a_hold: assert property (p_hold) else $error("host not held");
    property p_rx_stop;
        rx_valid_i && !asleep_o |=> !host_hold_o || asleep_o;
    endproperty
    a_rx_stop: assert property (p_rx_stop) else $error("delay not stopped");
    property p_quiet;
        $rose(cmd_mode_o) |-> !$past(rx_valid_i, 2) && !$past(rx_valid_i, 3);
    endproperty
    a_quiet: assert property (p_quiet) else $error("entry without silence");
endmodule
bind cmst_top cmst_checker #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_chk (.*);
`default_nettype wire

/* File: tb/cmst_host_model.sv */
// Purpose: host on the serial port, sends bytes
// Assumes: drives at the falling edge
// Notes: the byte lines show junk between bytes
`timescale 1ns/1ps
`default_nettype none
module cmst_host_model (
    input wire logic clk_sys_i, // clock
    output logic rx_valid_o, // byte strobe
    output logic [7:0] rx_byte_o // byte value
);
    initial begin
        {rx_valid_o, rx_byte_o} = '0;
    end
    task automatic send(input logic [7:0] b);
        @(negedge clk_sys_i);
        rx_valid_o = 1'b1;
        rx_byte_o = b;
        @(negedge clk_sys_i);
        rx_valid_o = 1'b0;
        rx_byte_o = ~b;
    endtask
    task automatic quiet(input int ms, cpm);
        repeat (ms * cpm) @(negedge clk_sys_i);
    endtask
    // spare 2 ms absorb tick jitter
    task automatic escape(input logic [7:0] c, input int gt, cpm);
        quiet(gt + 2, cpm);
        repeat (3) send(c);
        quiet(gt + 2, cpm);
    endtask
endmodule
`default_nettype wire

/* File: tb/cmst_tb.sv */
// Purpose: self-checking bench for cmst_top
// Assumes: CYCLES_PER_MS shortened to 4
// Notes: sleep pin and rx_busy_i stay low
`timescale 1ns/1ps
`default_nettype none
module cmst_tb;
    import cmst_pkg::*;
    localparam int CPM = 4;
    logic clk_sys_i, rst_i, rx_valid_i, cmd_valid_i, cmd_write_i, cmd_ok_o, cmd_err_o, cmd_mode_o;
    logic applied_o, sleep_pin_i, associated_i, tx_busy_i, rx_busy_i, asleep_o, radio_off_o;
    logic stay_assoc_o, host_hold_o;
    logic [7:0] rx_byte_i;
    cmst_sel_t cmd_sel_i;
    cmst_word_t cmd_wdata_i, cmd_rdata_o;
    int errors = 0, n_checks = 0, cyc = 0, k;
    cmst_top #(.CYCLES_PER_MS(CPM)) dut (.*);
    cmst_host_model host (.clk_sys_i, .rx_valid_o(rx_valid_i), .rx_byte_o(rx_byte_i));
    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    // ==========================================================
    // helpers
    task automatic check(input logic [23:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cmd(input logic w, cmst_sel_t s, cmst_word_t d, logic ok, cmst_word_t e);
        @(negedge clk_sys_i);
        cmd_valid_i = 1'b1;
        cmd_write_i = w;
        cmd_sel_i = s;
        cmd_wdata_i = d;
        @(negedge clk_sys_i);
        cmd_valid_i = 1'b0;
        check(cmd_ok_o, ok);
        check(cmd_err_o, !ok);
        if (!w && ok) check(cmd_rdata_o, e);
    endtask
    // wait on cmd_mode_o (m=1) or asleep_o; k counts cycles
    task automatic wait_on(input logic m, v, int n);
        for (k = 0; k < n && (m ? cmd_mode_o : asleep_o) !== v; k++) @(negedge clk_sys_i);
        check(m ? cmd_mode_o : asleep_o, v);
    endtask
    // ==========================================================
    // scenarios
    task automatic t_defaults();
        cmd(1'b1, IDX_GUARD_TIME, 24'h2, 1'b0, '0);
        host.escape(8'h2b, 1000, CPM);
        check(cmd_mode_o, 1'b1);
        for (int i = 0; i < NUM_REGS; i++) cmd(1'b0, cmst_sel_t'(i), '0, 1'b1, REG_RESET[i]);
        $display("defaults done");
    endtask
    task automatic t_pending();
        logic [7:0] modes [4] = '{8'h1, 8'h4, 8'h5, 8'h0};
        cmd(1'b1, IDX_GUARD_TIME, 24'h2, 1'b1, '0);
        cmd(1'b0, IDX_GUARD_TIME, '0, 1'b1, 24'h2);
        cmd(1'b1, IDX_SLEEP_MODE_SELECT, 24'h2, 1'b0, '0);
        cmd(1'b1, IDX_SLEEP_OPTIONS, 24'h40, 1'b0, '0);
        foreach (modes[i]) cmd(1'b1, IDX_SLEEP_MODE_SELECT, {16'h0, modes[i]}, 1'b1, '0);
        cmd(1'b1, IDX_ESCAPE_CHARACTER, 24'h41, 1'b1, '0);
        cmd(1'b1, IDX_COMMAND_TIMEOUT, 24'h2, 1'b1, '0);
        cmd(1'b1, SEL_APPLY_ACTION, '0, 1'b1, '0);
        check(applied_o, 1'b1);
        cmd(1'b1, SEL_EXIT_COMMAND, '0, 1'b1, '0);
        check({applied_o, cmd_mode_o}, 2'b10);
        $display("pending done");
    endtask
    task automatic t_abort();
        host.quiet(4, CPM);
        host.send(8'h41);
        host.send(8'h2b);
        repeat (2) host.send(8'h41);
        host.quiet(4, CPM);
        check(cmd_mode_o, 1'b0);
        repeat (4) host.send(8'h41);
        host.quiet(4, CPM);
        check(cmd_mode_o, 1'b0);
        host.escape(8'h41, 2, CPM);
        check(cmd_mode_o, 1'b1);
        host.quiet(90, CPM);
        check(cmd_mode_o, 1'b1);
        wait_on(1'b1, 1'b0, 150 * CPM);
        $display("abort and timeout done");
    endtask
    task automatic t_sleep();
        host.escape(8'h41, 2, CPM);
        cmd(1'b1, IDX_SLEEP_PERIOD, 24'h1, 1'b1, '0);
        cmd(1'b1, IDX_CYCLIC_WAKE_TIME, 24'h6, 1'b1, '0);
        cmd(1'b1, IDX_ASSOCIATION_TIMEOUT, 24'h3, 1'b1, '0);
        cmd(1'b1, IDX_WAKE_HOST_DELAY, 24'h3, 1'b1, '0);
        cmd(1'b1, IDX_SLEEP_OPTIONS, 24'h140, 1'b1, '0);
        cmd(1'b1, IDX_SLEEP_MODE_SELECT, 24'h4, 1'b1, '0);
        tx_busy_i = 1'b1;
        cmd(1'b1, SEL_EXIT_COMMAND, '0, 1'b1, '0);
        repeat (8) host.send(8'h00);
        host.quiet(12, CPM);
        check(asleep_o, 1'b0);
        tx_busy_i = 1'b0;
        wait_on(1'b0, 1'b1, 6 * CPM);
        check(k >= 2 * CPM, 1'b1);
        check({stay_assoc_o, radio_off_o}, 2'b10);
        wait_on(1'b0, 1'b0, 14 * CPM);
        check(host_hold_o, 1'b1);
        host.send(8'h00);
        check(host_hold_o, 1'b0);
        $display("sleep done");
    endtask
    // ==========================================================
    // main sequence and hang guard
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            give_verdict();
        end
    end
    initial begin
        rst_i = 1'b1;
        {cmd_valid_i, cmd_write_i, cmd_sel_i, cmd_wdata_i} = '0;
        {sleep_pin_i, associated_i, tx_busy_i, rx_busy_i} = '0;
        repeat (4) @(negedge clk_sys_i);
        rst_i = 1'b0;
        t_defaults();
        t_pending();
        t_abort();
        t_sleep();
        give_verdict();
    end
endmodule
`default_nettype wire
